// file: hdl/dhc_ref_holdover.sv
// Per-DPLL reference selection, holdover state and holdover filter
// What this block does
// [RQ1] Holdover filter bandwidth zero bypasses filter; holdover uses loop value.
// [RQ2] With filter enabled, holdover frequency word comes from filter output.
// [RQ3] Keep history of filter outputs; holdover applies newest or delayed one.
// [RQ4] Filter sits outside loop; bandwidth changes never touch loop path.
// [RQ5] Filter bandwidth programmed independently of loop bandwidth.
// [RQ6] Core frequency offset readable by host while locked.
// [RQ7] NCO mode seeded with holdover offset, then applies host writes.
// [RQ8] Unmanaged: state machine sets state and reference from validity, priority.
// [RQ9] Managed: host sets state and reference; device does not choose. Code still enters holdover on a masked holdover failure of the host reference.
// [RQ10] Leaving managed mode keeps current reference unless it must change.
// [RQ11] Each DPLL instance owns independent selection state.
// [RQ12] Select highest priority available reference; fall back in order.
// [RQ13] Switch reference on any failure whose switch-mask bit is one.
// [RQ14] All references failed: holdover when masked-in holdover failure.
// [RQ15] Leave holdover once no entry condition remains.
// [RQ16] Active reference exposed as status output.
// [RQ17] No masks set: keep locking to failed reference.
// [RQ18] Holdover entry and exit automatic on disqualify and qualify.
// [RQ19] Status pair: lock_held_n and holdover_flag encode state.
// [RQ20] Five modes: freerun, forced holdover, auto, forced ref, NCO.
// [RQ21] Failure flags are synchronous levels evaluated every cycle.
// [RQ22] History written at fixed interval; depth indexes samples back.
`timescale 1ns/100ps
`default_nettype none
module dhc_ref_holdover
   import dhc_pkg::*;
#(
   parameter int N_REFS = NUM_REFS,
   parameter longint HIST_CYCLES = HIST_INTERVAL_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // Reference monitor flags and enables, one bit per reference; priorities PRIO_W bits each
   input wire logic [N_REFS-1:0] signal_loss_fail_in,
   input wire logic [N_REFS-1:0] single_cycle_monitor_fail_in,
   input wire logic [N_REFS-1:0] coarse_freq_monitor_fail_in,
   input wire logic [N_REFS-1:0] precise_freq_monitor_fail_in,
   input wire logic [N_REFS-1:0] guard_timer_trigger_in,
   input wire logic [N_REFS-1:0] ref_enable_in,
   input wire logic [N_REFS*PRIO_W-1:0] ref_priority_in,
   // Control
   input wire logic [2:0] mode_in,
   input wire logic managed_in,
   input wire logic [REF_IDX_W-1:0] host_ref_sel_in,
   input wire logic host_holdover_in,
   input wire logic [FAIL_KINDS-1:0] switch_mask_in,
   input wire logic [FAIL_KINDS-1:0] holdover_mask_in,
   input wire logic [BW_W-1:0] holdover_filter_bw_in,
   input wire logic [HIST_IDX_W-1:0] holdover_history_depth_in,
   // Loop interface
   input wire logic [FREQ_W-1:0] loop_freq_in,
   input wire logic loop_phase_locked_in,
   // Host frequency offset access
   input wire logic [FREQ_W-1:0] freq_offset_value_in,
   input wire logic freq_offset_control_in,
   // Outputs
   output logic [FREQ_W-1:0] dco_freq_out,
   output logic [FREQ_W-1:0] freq_offset_read_out,
   output logic [REF_IDX_W-1:0] active_ref_out,
   output logic lock_held_n_out,
   output logic holdover_flag_out,
   output logic [1:0] dpll_state_out
);
   dhc_hist_if hist ();

   // Reset release through two flops
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // All state of this module apart from the reset synchronizer
   typedef struct packed {
      dhc_state_t st;
      logic [REF_IDX_W-1:0] ref_sel;
      logic [FREQ_W-1:0] filt;
      logic [FREQ_W-1:0] ho_val;
      logic [FREQ_W-1:0] dco;
      logic [FREQ_W-1:0] offs_rd;
      logic [CNT_W-1:0] samp_cnt;
      logic [HIST_IDX_W-1:0] wr_ptr;
      logic [HIST_IDX_W:0] fill;
      logic ho_load;
      logic nco_seeded;
      logic filt_init;
   } dhc_regs_t;

   dhc_regs_t r_q;
   dhc_regs_t r_d;

   // Per-reference qualification, evaluated each cycle [RQ21]
   logic [N_REFS-1:0] sw_fail;
   logic [N_REFS-1:0] ho_fail;
   logic [N_REFS-1:0] avail;
   genvar g;
   generate
      for (g = 0; g < N_REFS; g++) begin : g_ref
         logic [FAIL_KINDS-1:0] f;
         assign f = {guard_timer_trigger_in[g],
                     precise_freq_monitor_fail_in[g],
                     coarse_freq_monitor_fail_in[g],
                     single_cycle_monitor_fail_in[g],
                     signal_loss_fail_in[g]};
         assign sw_fail[g] = |(f & switch_mask_in); // [RQ13]
         assign ho_fail[g] = |(f & holdover_mask_in); // [RQ14]
         assign avail[g] = ref_enable_in[g] & ~sw_fail[g];
      end
   endgenerate

   // Highest priority available reference, lower index wins ties [RQ12]
   logic best_found;
   logic [REF_IDX_W-1:0] best_idx;
   always_comb begin
      logic [PRIO_W-1:0] best_p;
      logic [PRIO_W-1:0] p;
      best_p = '0;
      p = '0;
      best_found = 1'b0;
      best_idx = '0;
      for (int i = 0; i < N_REFS; i++) begin
         p = ref_priority_in[i*PRIO_W +: PRIO_W];
         if (avail[i] && (!best_found || p > best_p)) begin
            best_found = 1'b1;
            best_p = p;
            best_idx = REF_IDX_W'(i);
         end
      end
   end

   dhc_mode_t mode;
   assign mode = dhc_mode_t'(mode_in);

   logic cur_sw_fail;
   logic cur_ho_fail;
   assign cur_sw_fail = sw_fail[r_q.ref_sel];
   assign cur_ho_fail = ho_fail[r_q.ref_sel];

   logic filt_on;
   assign filt_on = (holdover_filter_bw_in != HO_FILTER_BYPASS); // [RQ1]

   logic [HIST_IDX_W-1:0] depth_eff;
   always_comb begin
      // Cannot reach back past what has been stored yet
      if ({1'b0, holdover_history_depth_in} >= r_q.fill) begin
         depth_eff = (r_q.fill == '0) ? '0
                     : HIST_IDX_W'(r_q.fill - 1'b1);
      end else begin
         depth_eff = holdover_history_depth_in;
      end
   end

   always_comb begin
      logic [FREQ_W-1:0] diff;
      logic [4:0] sh;
      logic go_ho;
      logic want_ho;
      r_d = r_q;
      diff = '0;
      go_ho = 1'b0;
      want_ho = 1'b0;
      sh = (holdover_filter_bw_in > BW_W'(FILT_SHIFT_MAX)) ? 5'(FILT_SHIFT_MAX)
           : holdover_filter_bw_in[4:0];
      r_d.ho_load = 1'b0;

      // Holdover filter: first-order IIR on loop word, outside the loop
      if (!r_q.filt_init) begin // [RQ4]
         r_d.filt = loop_freq_in;
         r_d.filt_init = 1'b1;
      end else if (r_q.st == DHC_ST_LOCKED && filt_on) begin // [RQ5]
         diff = loop_freq_in - r_q.filt;
         r_d.filt = r_q.filt + FREQ_W'($signed(diff) >>> sh);
      end

      // History sampling at a fixed interval while locked [RQ22]
      if (r_q.st == DHC_ST_LOCKED) begin
         if (r_q.samp_cnt == CNT_W'(HIST_CYCLES - 1)) begin
            r_d.samp_cnt = '0;
            r_d.wr_ptr = r_q.wr_ptr + 1'b1;
            if (r_q.fill != (HIST_IDX_W+1)'(HIST_DEPTH)) begin
               r_d.fill = r_q.fill + 1'b1;
            end
         end else begin
            r_d.samp_cnt = r_q.samp_cnt + 1'b1;
         end
      end

      // State and reference selection
      unique case (mode)
         DHC_MODE_FREERUN: begin
            r_d.st = DHC_ST_FREERUN; // [RQ20]
         end
         DHC_MODE_NCO: begin
            r_d.st = DHC_ST_FREERUN;
         end
         DHC_MODE_FORCED_HO: begin
            want_ho = 1'b1;
         end
         DHC_MODE_FORCED_REF: begin
            r_d.ref_sel = host_ref_sel_in;
            want_ho = ho_fail[host_ref_sel_in];
         end
         DHC_MODE_AUTO: begin
            if (managed_in) begin
               // Host decides; only masked holdover failures react [RQ9]
               r_d.ref_sel = host_ref_sel_in;
               want_ho = host_holdover_in | ho_fail[host_ref_sel_in];
            end else if (cur_sw_fail) begin
               // Current ref kept until it fails [RQ10] [RQ8]
               if (best_found) begin
                  r_d.ref_sel = best_idx; // [RQ12] [RQ13]
               end else begin
                  want_ho = |(ho_fail & ref_enable_in); // [RQ14]
               end
            end else if (best_found && ref_enable_in[r_q.ref_sel] == 1'b0) begin
               r_d.ref_sel = best_idx;
            end else if (best_found && (r_q.st == DHC_ST_HOLDOVER
                                        || r_q.st == DHC_ST_FREERUN)) begin
               // Take highest priority when recovering or starting [RQ12]
               r_d.ref_sel = best_idx;
            end else begin
               want_ho = cur_ho_fail; // [RQ17]
            end
         end
         default: begin
            r_d.st = DHC_ST_FREERUN;
         end
      endcase

      if (mode != DHC_MODE_FREERUN && mode != DHC_MODE_NCO) begin
         if (want_ho) begin
            go_ho = (r_q.st != DHC_ST_HOLDOVER);
            r_d.st = DHC_ST_HOLDOVER; // [RQ18]
         end else if (r_d.ref_sel != r_q.ref_sel) begin
            // Switch passes through acquisition on the new reference
            r_d.st = DHC_ST_ACQUIRE;
         end else if (r_q.st == DHC_ST_HOLDOVER
                      || r_q.st == DHC_ST_FREERUN) begin
            r_d.st = DHC_ST_ACQUIRE; // [RQ15]
         end else begin
            r_d.st = loop_phase_locked_in ? DHC_ST_LOCKED
                     : DHC_ST_ACQUIRE;
         end
      end

      // Holdover word selection on entry [RQ2] [RQ3]
      if (go_ho) begin
         r_d.ho_load = filt_on;
         r_d.ho_val = filt_on ? r_q.filt : loop_freq_in; // [RQ1]
      end
      if (r_q.ho_load && r_q.fill != '0) begin
         r_d.ho_val = hist.rd_data;
      end

      // Frequency word to oscillator
      if (mode == DHC_MODE_NCO) begin
         if (!r_q.nco_seeded) begin
            // Seed with the word that holdover would apply right now
            if (r_q.st == DHC_ST_HOLDOVER) begin
               r_d.dco = r_q.ho_val; // [RQ7]
            end else begin
               r_d.dco = filt_on ? r_q.filt : loop_freq_in; // [RQ7]
            end
            r_d.nco_seeded = 1'b1;
         end else if (freq_offset_control_in) begin
            r_d.dco = freq_offset_value_in; // [RQ7]
         end
      end else begin
         r_d.nco_seeded = 1'b0;
         r_d.dco = (r_q.st == DHC_ST_HOLDOVER) ? r_q.ho_val
                   : loop_freq_in;
      end

      if (r_q.st == DHC_ST_LOCKED) begin
         r_d.offs_rd = loop_freq_in; // [RQ6]
      end
   end

   // History store port
   assign hist.wr_en = (r_q.st == DHC_ST_LOCKED)
                       && (r_q.samp_cnt == CNT_W'(HIST_CYCLES - 1));
   assign hist.wr_addr = r_q.wr_ptr;
   assign hist.wr_data = r_q.filt;
   assign hist.rd_addr = r_q.wr_ptr - 1'b1 - depth_eff; // [RQ3]

   dhc_hist_mem u_hist (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .port(hist.mem)
   );

   // Selection state lives only in this instance [RQ11]
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign dco_freq_out = r_q.dco;
   assign freq_offset_read_out = r_q.offs_rd;
   assign active_ref_out = r_q.ref_sel; // [RQ16]
   assign lock_held_n_out = (r_q.st == DHC_ST_LOCKED); // [RQ19]
   assign holdover_flag_out = (r_q.st == DHC_ST_HOLDOVER); // [RQ19]
   assign dpll_state_out = r_q.st;

   // Assertions
   property p_status_code;
      @(posedge mclk_in) disable iff (!rst_n)
      !(lock_held_n_out && holdover_flag_out);
   endproperty
   a_status_code: assert property (p_status_code) // [RQ19]
      else $error("lock and holdover flags both set");

   property p_switch_away;
      @(posedge mclk_in) disable iff (!rst_n)
      (mode == DHC_MODE_AUTO && !managed_in && cur_sw_fail && best_found)
      |=> (active_ref_out == $past(best_idx));
   endproperty
   a_switch_away: assert property (p_switch_away) // [RQ13]
      else $error("failed reference not replaced by best one");

   property p_all_fail_ho;
      @(posedge mclk_in) disable iff (!rst_n)
      (mode == DHC_MODE_AUTO && !managed_in && cur_sw_fail && !best_found
       && |(ho_fail & ref_enable_in)) |=> holdover_flag_out;
   endproperty
   a_all_fail_ho: assert property (p_all_fail_ho) // [RQ14]
      else $error("holdover not entered with all references failed");

   property p_managed_ref;
      @(posedge mclk_in) disable iff (!rst_n)
      (mode == DHC_MODE_AUTO && managed_in)
      |=> (active_ref_out == $past(host_ref_sel_in));
   endproperty
   a_managed_ref: assert property (p_managed_ref) // [RQ9]
      else $error("managed reference not followed");

   property p_ho_word;
      @(posedge mclk_in) disable iff (!rst_n)
      (holdover_flag_out && mode != DHC_MODE_NCO) |=> ##1
      (dco_freq_out == $past(r_q.ho_val, 1) || !$past(holdover_flag_out));
   endproperty
   a_ho_word: assert property (p_ho_word) // [RQ2]
      else $error("oscillator word not from holdover value");

   property p_bypass;
      @(posedge mclk_in) disable iff (!rst_n)
      (!filt_on && holdover_flag_out && !$past(holdover_flag_out)
       && mode != DHC_MODE_NCO) |-> (r_q.ho_val == $past(loop_freq_in));
   endproperty
   a_bypass: assert property (p_bypass) // [RQ1]
      else $error("bypass holdover value not from loop");

   property p_offs_read;
      @(posedge mclk_in) disable iff (!rst_n)
      lock_held_n_out |=> (freq_offset_read_out == $past(loop_freq_in));
   endproperty
   a_offs_read: assert property (p_offs_read) // [RQ6]
      else $error("offset readback stale while locked");

   property p_nco_write;
      @(posedge mclk_in) disable iff (!rst_n)
      (mode == DHC_MODE_NCO && r_q.nco_seeded && freq_offset_control_in)
      |=> (dco_freq_out == $past(freq_offset_value_in));
   endproperty
   a_nco_write: assert property (p_nco_write) // [RQ7]
      else $error("host offset write not applied");

   property p_freerun;
      @(posedge mclk_in) disable iff (!rst_n)
      (mode == DHC_MODE_FREERUN) [*2] |-> dpll_state_out == DHC_ST_FREERUN;
   endproperty
   a_freerun: assert property (p_freerun) // [RQ20]
      else $error("freerun mode not in freerun state");
endmodule
`default_nettype wire

// file: shared/dhc_pkg.sv
// Shared constants and types for the reference select and holdover block
package dhc_pkg;
   localparam int NUM_REFS = 4;
   localparam int REF_IDX_W = 2;
   localparam int PRIO_W = 4;
   localparam int FREQ_W = 32;
   localparam int BW_W = 8;
   localparam int HIST_DEPTH = 64;
   localparam int HIST_IDX_W = 6;
   localparam int FAIL_KINDS = 5;
   localparam logic [BW_W-1:0] HO_FILTER_BYPASS = 8'h00;
   // Fail vector bit positions
   localparam int FAIL_LOS = 0;
   localparam int FAIL_SCM = 1;
   localparam int FAIL_CFM = 2;
   localparam int FAIL_PFM = 3;
   localparam int FAIL_GST = 4;
   // History sampling interval: 60 s between samples gives over one hour
   localparam longint HIST_INTERVAL_MS = 64'd60000;
   localparam longint CLK_HZ = 64'd50000000;
   localparam longint HIST_INTERVAL_CYC = (HIST_INTERVAL_MS * CLK_HZ) / 1000;
   localparam int CNT_W = 32;
   localparam int FILT_SHIFT_MAX = 31;

   typedef enum logic [2:0] {
      DHC_MODE_FREERUN = 3'b000,
      DHC_MODE_FORCED_HO = 3'b001,
      DHC_MODE_AUTO = 3'b010,
      DHC_MODE_FORCED_REF = 3'b011,
      DHC_MODE_NCO = 3'b100
   } dhc_mode_t;

   typedef enum logic [1:0] {
      DHC_ST_FREERUN = 2'b00,
      DHC_ST_ACQUIRE = 2'b01,
      DHC_ST_LOCKED = 2'b10,
      DHC_ST_HOLDOVER = 2'b11
   } dhc_state_t;
endpackage

// file: shared/dhc_hist_if.sv
// History store carrier between control core and memory
`timescale 1ns/100ps
`default_nettype none
interface dhc_hist_if;
   import dhc_pkg::*;
   logic wr_en;
   logic [HIST_IDX_W-1:0] wr_addr;
   logic [FREQ_W-1:0] wr_data;
   logic [HIST_IDX_W-1:0] rd_addr;
   logic [FREQ_W-1:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// file: hdl/dhc_hist_mem.sv
// Holdover history memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module dhc_hist_mem
   import dhc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Access port
   dhc_hist_if.mem port
);
   logic [FREQ_W-1:0] mem_q [HIST_DEPTH];
   logic [FREQ_W-1:0] rd_q;

   // Storage array has no reset so it maps to RAM
   always_ff @(posedge clk_in) begin
      if (port.wr_en) begin
         mem_q[port.wr_addr] <= port.wr_data;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_q <= '0;
      end else begin
         rd_q <= mem_q[port.rd_addr];
      end
   end

   assign port.rd_data = rd_q;
endmodule
`default_nettype wire

// file: bench/dhc_ref_mon_model.sv
// Reference monitor and loop lock model facing the selection block
`timescale 1ns/100ps
`default_nettype none
module dhc_ref_mon_model
   import dhc_pkg::*;
#(
   parameter int LOCK_DLY = 8
) (
   // Clock
   input wire logic clk_in,
   // Failure commands from the bench
   input wire logic [NUM_REFS-1:0] fail_refs_in,
   input wire logic [FAIL_KINDS-1:0] fail_kind_in,
   // Observed selection state
   input wire logic [1:0] state_in,
   input wire logic [REF_IDX_W-1:0] ref_in,
   // Monitor flags and loop lock
   output var logic [NUM_REFS-1:0] los_out,
   output var logic [NUM_REFS-1:0] scm_out,
   output var logic [NUM_REFS-1:0] cfm_out,
   output var logic [NUM_REFS-1:0] pfm_out,
   output var logic [NUM_REFS-1:0] gst_out,
   output var logic locked_out
);
   int cnt = 0;
   logic [REF_IDX_W-1:0] last_ref = '0;
   initial begin
      locked_out = 1'b0;
   end
   // Flags follow the falling-edge commands at once: no race at that edge
   always_comb begin
      los_out = fail_refs_in & {NUM_REFS{fail_kind_in[FAIL_LOS]}};
      scm_out = fail_refs_in & {NUM_REFS{fail_kind_in[FAIL_SCM]}};
      cfm_out = fail_refs_in & {NUM_REFS{fail_kind_in[FAIL_CFM]}};
      pfm_out = fail_refs_in & {NUM_REFS{fail_kind_in[FAIL_PFM]}};
      gst_out = fail_refs_in & {NUM_REFS{fail_kind_in[FAIL_GST]}};
   end
   always @(negedge clk_in) begin
      last_ref <= ref_in;
      // A new reference or a lost lock state restarts acquisition
      if ((state_in == DHC_ST_ACQUIRE || state_in == DHC_ST_LOCKED) &&
          ref_in == last_ref) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
      end
      locked_out <= (cnt >= LOCK_DLY);
   end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for reference selection and holdover control
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dhc_pkg::*;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [3:0] ref_en = 4'hf;
   logic [15:0] prio = 16'h5931;
   logic [2:0] mode = DHC_MODE_AUTO;
   logic managed = 1'b0;
   logic host_ho = 1'b0;
   logic [1:0] host_sel = 2'h0;
   logic [4:0] sw_mask = 5'h1f;
   logic [4:0] ho_mask = 5'h1f;
   logic [7:0] bw = 8'h00;
   logic [5:0] depth = 6'h00;
   logic [31:0] loop_w = 32'h1234_5678;
   logic [31:0] off_v = 32'h0000_0000;
   logic off_c = 1'b0;
   logic [3:0] fail_refs = 4'h0;
   logic [4:0] fail_kind = 5'h00;
   logic [3:0] signal_loss_fail, single_cycle_monitor_fail, coarse_freq_monitor_fail, precise_freq_monitor_fail, guard_timer_trigger;
   logic ph_lock;
   logic [31:0] dco, off_rd;
   logic [1:0] act_ref, st;
   logic lock_n, ho_f;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;

   always #10 mclk_in = ~mclk_in;

   dhc_ref_holdover #(.HIST_CYCLES(8)) dhc_ref_holdover_inst (
      .mclk_in(mclk_in), .rstn_in(rstn_in),
      .signal_loss_fail_in(signal_loss_fail), .single_cycle_monitor_fail_in(single_cycle_monitor_fail),
      .coarse_freq_monitor_fail_in(coarse_freq_monitor_fail), .precise_freq_monitor_fail_in(precise_freq_monitor_fail),
      .guard_timer_trigger_in(guard_timer_trigger), .ref_enable_in(ref_en),
      .ref_priority_in(prio), .mode_in(mode), .managed_in(managed),
      .host_ref_sel_in(host_sel), .host_holdover_in(host_ho),
      .switch_mask_in(sw_mask), .holdover_mask_in(ho_mask),
      .holdover_filter_bw_in(bw), .holdover_history_depth_in(depth),
      .loop_freq_in(loop_w), .loop_phase_locked_in(ph_lock),
      .freq_offset_value_in(off_v), .freq_offset_control_in(off_c),
      .dco_freq_out(dco), .freq_offset_read_out(off_rd),
      .active_ref_out(act_ref), .lock_held_n_out(lock_n),
      .holdover_flag_out(ho_f), .dpll_state_out(st));

   dhc_ref_mon_model dhc_ref_mon_model_inst (
      .clk_in(mclk_in), .fail_refs_in(fail_refs), .fail_kind_in(fail_kind),
      .state_in(st), .ref_in(act_ref), .los_out(signal_loss_fail), .scm_out(single_cycle_monitor_fail),
      .cfm_out(coarse_freq_monitor_fail), .pfm_out(precise_freq_monitor_fail), .gst_out(guard_timer_trigger), .locked_out(ph_lock));

   task automatic wrap_up();
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Generous ceiling: each scenario needs under 200 cycles
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask

   // State, flag pair and optionally the selected reference
   task automatic chk_status(input logic [1:0] es, input logic [1:0] er,
                             input logic use_ref);
      logic ok;
      n_compared++;
      ok = (st === es) && (lock_n === (es == DHC_ST_LOCKED)) &&
           (ho_f === (es == DHC_ST_HOLDOVER)) && (!use_ref || act_ref === er);
      if (!ok) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time,
                  {st, act_ref, lock_n, ho_f},
                  {es, er, es == DHC_ST_LOCKED, es == DHC_ST_HOLDOVER});
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_lock();
      for (int i = 0; i < 40 && lock_n !== 1'b1; i++) begin
         wait_cyc(1);
      end
   endtask

   // Fresh start in automatic unmanaged mode, locked to the best reference
   task automatic setup_locked();
      rstn_in = 1'b0;
      {mode, managed, host_sel, host_ho} = {DHC_MODE_AUTO, 1'b0, 2'h0, 1'b0};
      {sw_mask, ho_mask, bw, fail_refs, fail_kind} = {5'h1f, 5'h1f, 8'h00,
                                                      4'h0, 5'h00};
      {loop_w, off_c} = {32'h1234_5678, 1'b0};
      wait_cyc(16);
      rstn_in = 1'b1;
      wait_cyc(5);
      chk_status(DHC_ST_ACQUIRE, 2'h2, 1'b1);
      wait_lock();
      chk_status(DHC_ST_LOCKED, 2'h2, 1'b1);
      wait_cyc(1);
      chk_word(off_rd, loop_w);
   endtask

   // Narrow filter keeps the old word; holdover takes it from history
   task automatic t_filter();
      setup_locked();
      {bw, depth} = {8'h1f, 6'h03};
      wait_cyc(40);
      loop_w = 32'h2234_5678;
      wait_cyc(2);
      chk_word(dco, 32'h2234_5678);
      {fail_refs, fail_kind} = {4'hf, 5'h01};
      wait_cyc(5);
      chk_status(DHC_ST_HOLDOVER, 2'h2, 1'b1);
      chk_word(dco, 32'h1234_5678);
   endtask

   // Each failure kind switches only when its own mask bit is set
   task automatic t_switch();
      for (int k = 0; k < FAIL_KINDS; k++) begin
         setup_locked();
         {sw_mask, ho_mask} = {~(5'h01 << k), 5'h00};
         {fail_refs, fail_kind} = {4'h4, 5'h01 << k};
         wait_cyc(4);
         chk_status(DHC_ST_LOCKED, 2'h2, 1'b1);
         sw_mask = 5'h01 << k;
         wait_cyc(3);
         chk_status(DHC_ST_ACQUIRE, 2'h3, 1'b1);
      end
   endtask

   task automatic t_holdover();
      setup_locked();
      {sw_mask, ho_mask} = {5'h1f, 5'h01};
      {fail_refs, fail_kind} = {4'hf, 5'h01};
      wait_cyc(4);
      chk_status(DHC_ST_HOLDOVER, 2'h0, 1'b0);
      loop_w = 32'h0bad_0001;
      wait_cyc(4);
      chk_word(dco, 32'h1234_5678);
      {fail_refs, fail_kind} = {4'h0, 5'h00};
      wait_cyc(3);
      chk_status(DHC_ST_ACQUIRE, 2'h2, 1'b1);
   endtask

   task automatic t_managed();
      setup_locked();
      {managed, host_sel} = {1'b1, 2'h1};
      wait_cyc(6);
      wait_lock();
      chk_status(DHC_ST_LOCKED, 2'h1, 1'b1);
      managed = 1'b0;
      wait_cyc(6);
      chk_status(DHC_ST_LOCKED, 2'h1, 1'b1);
      {fail_refs, fail_kind} = {4'h2, 5'h01};
      wait_cyc(3);
      chk_status(DHC_ST_ACQUIRE, 2'h2, 1'b1);
   endtask

   task automatic t_modes();
      setup_locked();
      mode = DHC_MODE_FORCED_HO;
      wait_cyc(4);
      chk_status(DHC_ST_HOLDOVER, 2'h0, 1'b0);
      {mode, host_sel} = {DHC_MODE_FORCED_REF, 2'h0};
      wait_cyc(6);
      wait_lock();
      chk_status(DHC_ST_LOCKED, 2'h0, 1'b1);
      {fail_refs, fail_kind, ho_mask} = {4'h1, 5'h02, 5'h02};
      wait_cyc(4);
      chk_status(DHC_ST_HOLDOVER, 2'h0, 1'b0);
      mode = DHC_MODE_FREERUN;
      wait_cyc(4);
      chk_status(DHC_ST_FREERUN, 2'h0, 1'b0);
   endtask

   // NCO seeds from locked with the bypassed loop word, then follows a host write
   task automatic t_nco();
      setup_locked();
      mode = DHC_MODE_NCO;
      wait_cyc(3);
      chk_word(dco, 32'h1234_5678);
      {off_v, off_c} = {32'h0000_0abc, 1'b1};
      wait_cyc(1);
      off_c = 1'b0;
      wait_cyc(1);
      chk_word(dco, 32'h0000_0abc);
   endtask

   initial begin
      t_switch();
      t_holdover();
      t_filter();
      t_managed();
      t_modes();
      t_nco();
      wrap_up();
   end
endmodule
`default_nettype wire
